// ### mcr_pkg.sv
// mcr_pkg: constants, types and register map of the mode and calibration reply builder
// assumes one 100 MHz clock and an axi4-lite register bus
package mcr_pkg;
  localparam logic [7:0] MCR_CODE_MODE = 8'h71;
  localparam logic [7:0] MCR_CODE_CAL_THR = 8'h20;
  localparam logic [7:0] MCR_CODE_CAL_BRK = 8'h21;
  localparam logic [7:0] MCR_CODE_CAL_TRN = 8'h22;
  localparam logic [7:0] MCR_FILL = 8'hff;
  localparam logic [7:0] MCR_CAL_FILL = 8'h00;
  localparam logic [7:0] MCR_MODE_NORMAL = 8'h00;
  localparam logic [7:0] MCR_MODE_DIAG = 8'h01;
  localparam logic [7:0] MCR_MODE_CAL = 8'h09;
  localparam logic [7:0] MCR_MODE_ERROR = 8'h0a;
  localparam logic [7:0] MCR_MODE_BOOT = 8'h10;
  localparam logic [7:0] MCR_PH_MAX = 8'h06;
  localparam logic [7:0] MCR_PH_DONE = 8'h09;
  localparam int MCR_CLK_MHZ = 100;
  localparam int MCR_PERIOD_MS = 100;
  localparam int MCR_PERIOD_CYC = MCR_PERIOD_MS * 1000 * MCR_CLK_MHZ;
  localparam logic [7:0] MCR_ADDR_CTRL = 8'h00;
  localparam logic [7:0] MCR_ADDR_REQ = 8'h04;
  localparam logic [7:0] MCR_ADDR_STAT = 8'h08;
  localparam logic [7:0] MCR_ADDR_TXLO = 8'h0c;
  localparam logic [7:0] MCR_ADDR_TXHI = 8'h10;
  localparam logic [7:0] MCR_RST_MODE = 8'h00;
  localparam logic [1:0] MCR_RESP_OKAY = 2'b00;
  localparam logic [1:0] MCR_RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [7:0] b4;
    logic [7:0] b5;
    logic [7:0] b6;
    logic [7:0] b7;
    logic [7:0] b8;
  } mcr_frame_t;

  typedef struct packed {
    logic valid;
    mcr_frame_t data;
  } mcr_req_t;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } mcr_axi_in_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } mcr_axi_out_t;

  typedef enum logic [1:0] {MCR_IDLE, MCR_SEND} mcr_tx_state_t;
endpackage

// ### mcr_period_timer.sv
// mcr_period_timer: one-cycle tick every period while enabled
// assumes sys_clk at 100 MHz; restarts from zero whenever enable drops
`timescale 1ns/100ps
`default_nettype none
module mcr_period_timer #(
  parameter int PERIOD = 10000000
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic enable,
  output logic tick
);
  import mcr_pkg::*;
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  always_comb begin
    cnt_nxt = cnt_r;
    if (!enable || cnt_r == 32'(PERIOD - 1)) begin
      cnt_nxt = 32'h0;
    end else begin
      cnt_nxt = cnt_r + 32'h1;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_r <= 32'h0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
  assign tick = enable && cnt_r == 32'(PERIOD - 1);
endmodule
`default_nettype wire

// ### mcr_reply.sv
// mcr_reply: takes host request frames, keeps mode and calibration state, emits reply frames
// assumes requests and tx_ready synchronous to sys_clk; one frame in flight at a time
//
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module mcr_reply #(
  parameter int PERIOD_CYC = mcr_pkg::MCR_PERIOD_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire mcr_pkg::mcr_req_t req,
  input wire logic req_from_flasher,
  output logic req_ready,
  output mcr_pkg::mcr_frame_t tx_frame,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire mcr_pkg::mcr_axi_in_t axi_in,
  output mcr_pkg::mcr_axi_out_t axi_out
);
  import mcr_pkg::*;

  function automatic logic mode_legal(input logic [7:0] m, input logic flash);
    logic ok;
    ok = (m == MCR_MODE_NORMAL) || (m == MCR_MODE_DIAG) || (m == MCR_MODE_CAL) ||
         (m == MCR_MODE_ERROR) || (m == MCR_MODE_BOOT && flash);
    return ok;
  endfunction

  function automatic logic is_cal_code(input logic [7:0] c);
    return c == MCR_CODE_CAL_THR || c == MCR_CODE_CAL_BRK || c == MCR_CODE_CAL_TRN;
  endfunction

  mcr_tx_state_t st_r, st_nxt;
  mcr_frame_t frame_r, frame_nxt;
  logic [7:0] mode_r, mode_nxt;
  logic cal_act_r, cal_act_nxt;
  logic [7:0] cal_code_r, cal_code_nxt;
  logic [7:0] phase_r, phase_nxt;
  logic [7:0] refused_r, refused_nxt;
  logic [15:0] sent_r, sent_nxt;
  logic tick;
  logic tick_pend_r, tick_pend_nxt;
  logic abort_w;
  logic [7:0] phase_w;
  logic phase_we;

  mcr_period_timer #(.PERIOD(PERIOD_CYC)) u_timer (
    .sys_clk(sys_clk),
    .rst(rst),
    .enable(cal_act_r),
    .tick(tick)
  );

  assign req_ready = st_r == MCR_IDLE;
  assign tx_valid = st_r == MCR_SEND;
  assign tx_frame = frame_r;

  always_comb begin
    st_nxt = st_r;
    frame_nxt = frame_r;
    mode_nxt = mode_r;
    cal_act_nxt = cal_act_r;
    cal_code_nxt = cal_code_r;
    phase_nxt = phase_r;
    refused_nxt = refused_r;
    sent_nxt = sent_r;
    tick_pend_nxt = tick_pend_r || tick;
    if (phase_we && phase_w <= MCR_PH_MAX || phase_we && phase_w == MCR_PH_DONE) begin
      phase_nxt = phase_w;
    end
    if (abort_w) begin
      cal_act_nxt = 1'b0;
      mode_nxt = MCR_MODE_NORMAL;
    end
    case (st_r)
      MCR_IDLE: begin
        if (req.valid) begin
          // requests win over a pending periodic reply; the tick waits one frame
          frame_nxt = '{b1: req.data.b1, b2: mode_r, b3: MCR_FILL, b4: MCR_FILL,
                        b5: MCR_FILL, b6: MCR_FILL, b7: MCR_FILL, b8: MCR_FILL};
          st_nxt = MCR_SEND;
          if (req.data.b1 == MCR_CODE_MODE) begin
            frame_nxt.b1 = MCR_CODE_MODE;
            if (mode_legal(req.data.b2, req_from_flasher)) begin
              mode_nxt = req.data.b2;
              frame_nxt.b2 = req.data.b2;
              cal_act_nxt = req.data.b2 == MCR_MODE_CAL;
            end else begin
              refused_nxt = req.data.b2;
            end
          end else if (is_cal_code(req.data.b1)) begin
            cal_act_nxt = 1'b1;
            cal_code_nxt = req.data.b1;
            mode_nxt = MCR_MODE_CAL;
            frame_nxt = '{b1: req.data.b1, b2: phase_r, b3: MCR_CAL_FILL, b4: MCR_FILL,
                          b5: MCR_FILL, b6: MCR_FILL, b7: MCR_FILL, b8: MCR_FILL};
          end else begin
            st_nxt = MCR_IDLE;
          end
        end else if (tick_pend_r && cal_act_r) begin
          tick_pend_nxt = tick;
          frame_nxt = '{b1: cal_code_r, b2: phase_r, b3: MCR_CAL_FILL, b4: MCR_FILL,
                        b5: MCR_FILL, b6: MCR_FILL, b7: MCR_FILL, b8: MCR_FILL};
          st_nxt = MCR_SEND;
        end
      end
      MCR_SEND: begin
        if (tx_ready) begin
          st_nxt = MCR_IDLE;
          sent_nxt = sent_r + 16'h1;
        end
      end
      default: st_nxt = MCR_IDLE;
    endcase
    if (!cal_act_nxt) begin
      tick_pend_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r <= MCR_IDLE;
      frame_r <= '1;
      mode_r <= MCR_RST_MODE;
      cal_act_r <= 1'b0;
      cal_code_r <= MCR_CODE_CAL_THR;
      phase_r <= 8'h00;
      refused_r <= 8'h00;
      sent_r <= 16'h0;
      tick_pend_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      frame_r <= frame_nxt;
      mode_r <= mode_nxt;
      cal_act_r <= cal_act_nxt;
      cal_code_r <= cal_code_nxt;
      phase_r <= phase_nxt;
      refused_r <= refused_nxt;
      sent_r <= sent_nxt;
      tick_pend_r <= tick_pend_nxt;
    end
  end

  // axi4-lite slave: one write and one read at a time
  logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt, bvalid_r, bvalid_nxt;
  logic [7:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic wr_fire;

  assign wr_fire = aw_got_r && w_got_r && !bvalid_r;
  assign abort_w = wr_fire && awaddr_r == MCR_ADDR_CTRL && wdata_r[8];
  assign phase_we = wr_fire && awaddr_r == MCR_ADDR_CTRL;
  assign phase_w = wdata_r[7:0];

  always_comb begin
    aw_got_nxt = aw_got_r;
    w_got_nxt = w_got_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (axi_in.awvalid && !aw_got_r) begin
      aw_got_nxt = 1'b1;
      awaddr_nxt = axi_in.awaddr;
    end
    if (axi_in.wvalid && !w_got_r) begin
      w_got_nxt = 1'b1;
      wdata_nxt = axi_in.wdata;
    end
    if (wr_fire) begin
      bvalid_nxt = 1'b1;
      bresp_nxt = awaddr_r == MCR_ADDR_CTRL ? MCR_RESP_OKAY : MCR_RESP_SLVERR;
    end
    if (bvalid_r && axi_in.bready) begin
      bvalid_nxt = 1'b0;
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
    end
    if (axi_in.arvalid && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = MCR_RESP_OKAY;
      case (axi_in.araddr)
        MCR_ADDR_CTRL: rdata_nxt = {24'h0, phase_r};
        MCR_ADDR_REQ: rdata_nxt = {16'h0, refused_r, cal_code_r};
        MCR_ADDR_STAT: rdata_nxt = {sent_r, 6'h0, cal_act_r, tx_valid, mode_r};
        MCR_ADDR_TXLO: rdata_nxt = frame_r[31:0];
        MCR_ADDR_TXHI: rdata_nxt = frame_r[63:32];
        default: begin
          rdata_nxt = 32'h0;
          rresp_nxt = MCR_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && axi_in.rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 8'h0;
      wdata_r <= 32'h0;
      bvalid_r <= 1'b0;
      bresp_r <= MCR_RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= MCR_RESP_OKAY;
    end else begin
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  assign axi_out = '{awready: !aw_got_r, wready: !w_got_r, bvalid: bvalid_r, bresp: bresp_r,
                     arready: !rvalid_r, rvalid: rvalid_r, rdata: rdata_r, rresp: rresp_r};

  AST_ECHO: assert property (@(posedge sys_clk) disable iff (rst)
    req.valid && req_ready && (req.data.b1 == MCR_CODE_MODE || is_cal_code(req.data.b1))
    |=> tx_valid && tx_frame.b1 == $past(req.data.b1)) else $error("reply code not echoed");
  AST_MODE_CODE: assert property (@(posedge sys_clk) disable iff (rst)
    req.valid && req_ready && req.data.b1 == MCR_CODE_MODE
    |=> tx_frame.b1 == 8'h71) else $error("mode reply code wrong");
  AST_MODE_BYTE: assert property (@(posedge sys_clk) disable iff (rst)
    tx_valid && tx_frame.b1 == MCR_CODE_MODE |-> tx_frame.b2 == mode_r)
    else $error("mode byte differs from mode");
  AST_FILL: assert property (@(posedge sys_clk) disable iff (rst)
    tx_valid && tx_frame.b1 == MCR_CODE_MODE |-> tx_frame[47:0] == 48'hffffffffffff)
    else $error("mode reply fill not ff");
  AST_NO_BOOT: assert property (@(posedge sys_clk) disable iff (rst)
    req.valid && req_ready && req.data.b1 == MCR_CODE_MODE && !req_from_flasher &&
    req.data.b2 == MCR_MODE_BOOT && mode_r != MCR_MODE_BOOT |=> mode_r != MCR_MODE_BOOT)
    else $error("bootloader entered without flasher");
  AST_PERIOD: assert property (@(posedge sys_clk) disable iff (rst)
    tick && cal_act_r && !abort_w |-> ##[1:8] (tx_valid && is_cal_code(tx_frame.b1)))
    else $error("periodic calibration reply missing");
  AST_CAL_CODE: assert property (@(posedge sys_clk) disable iff (rst)
    tx_valid && tx_frame.b3 == MCR_CAL_FILL |-> is_cal_code(tx_frame.b1))
    else $error("bad calibration reply code");
  AST_PHASE: assert property (@(posedge sys_clk) disable iff (rst)
    phase_r <= MCR_PH_MAX || phase_r == MCR_PH_DONE) else $error("illegal phase");
  AST_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_frame))
    else $error("frame changed while waiting");
  COV_MODE: cover property (@(posedge sys_clk) tx_valid && tx_ready && tx_frame.b1 == 8'h71);
  COV_CAL: cover property (@(posedge sys_clk) tick && cal_act_r);
  COV_BOOT: cover property (@(posedge sys_clk) mode_r == MCR_MODE_BOOT);
endmodule
`default_nettype wire

// ### mcr_host_model.sv
// mcr_host_model: requester and frame sink on the far side of the reply builder
// assumes one clock; requests and ready change just after the rising edge
`timescale 1ns/100ps
`default_nettype none
module mcr_host_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic slow,
  output mcr_pkg::mcr_req_t req,
  output logic req_from_flasher,
  input wire logic req_ready,
  input wire mcr_pkg::mcr_frame_t tx_frame,
  input wire logic tx_valid,
  output logic tx_ready
);
  import mcr_pkg::*;
  mcr_frame_t got[$];
  int t[$];
  int cyc_r = 0;
  logic [1:0] ph_r = 2'd0;
  // tx_ready takes its first value at the first edge, while reset is still high
  initial begin
    req = '0;
    req_from_flasher = 1'b0;
  end
  // slow sink stalls three cycles of four, so a reply must hold its frame
  always @(posedge sys_clk) begin
    cyc_r <= cyc_r + 1;
    ph_r <= ph_r + 2'd1;
    tx_ready <= !rst && (!slow || ph_r == 2'd3);
    if (tx_valid && tx_ready) begin
      got.push_back(tx_frame);
      t.push_back(cyc_r);
    end
  end
  // ready is sampled at the falling edge: it only moves at rising edges
  task automatic send(input logic [7:0] code, input logic [7:0] md, input logic fl);
    logic hit;
    int n;
    hit = 1'b0;
    n = 0;
    req.valid <= 1'b1;
    req.data <= {code, md, {6{MCR_FILL}}};
    req_from_flasher <= fl;
    while (!hit && n < 300) begin
      @(negedge sys_clk);
      hit = req_ready === 1'b1;
      n++;
      @(posedge sys_clk);
    end
    // released data shows the inverse, never a stale copy
    req.valid <= 1'b0;
    req.data <= ~{code, md, {6{MCR_FILL}}};
    req_from_flasher <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### mode_and_calibration_reply_bench.sv
// mode_and_calibration_reply_bench: self-checking bench for mcr_reply
// assumes mcr_host_model as far side; period shortened to 100 cycles
`timescale 1ns/100ps
`default_nettype none
module mode_and_calibration_reply_bench;
  import mcr_pkg::*;
  localparam int PER = 100;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic slow = 1'b0;
  mcr_req_t req;
  logic req_from_flasher, req_ready, tx_valid, tx_ready;
  mcr_frame_t tx_frame, f;
  mcr_axi_in_t axi_in = '0;
  mcr_axi_out_t axi_out;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [1:0] r;
  logic [31:0] d;
  logic [7:0] md[5] = '{8'h01, 8'h09, 8'h0a, 8'h10, 8'h00};
  logic [7:0] cc[3] = '{8'h20, 8'h21, 8'h22};
  always #5 sys_clk = ~sys_clk;
  mcr_reply #(.PERIOD_CYC(PER)) dut (.sys_clk(sys_clk), .rst(rst), .req(req),
    .req_from_flasher(req_from_flasher), .req_ready(req_ready), .tx_frame(tx_frame),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .axi_in(axi_in), .axi_out(axi_out));
  mcr_host_model host (.sys_clk(sys_clk), .rst(rst), .slow(slow), .req(req),
    .req_from_flasher(req_from_flasher), .req_ready(req_ready), .tx_frame(tx_frame),
    .tx_valid(tx_valid), .tx_ready(tx_ready));
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      final_report();
    end
  end
  task automatic chk(input string what, input logic [63:0] e, input logic [63:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  // handshakes are seen at the falling edge and acted on at the next rising edge
  task automatic axw(input logic [7:0] a, input logic [31:0] wd, output logic [1:0] rs);
    logic aw, w, b;
    int n;
    n = 0;
    b = 1'b0;
    axi_in.awaddr <= a;
    axi_in.wdata <= wd;
    axi_in.wstrb <= 4'hf;
    axi_in.awvalid <= 1'b1;
    axi_in.wvalid <= 1'b1;
    axi_in.bready <= 1'b1;
    while (!b && n < 100) begin
      @(negedge sys_clk);
      aw = axi_in.awvalid && axi_out.awready === 1'b1;
      w = axi_in.wvalid && axi_out.wready === 1'b1;
      b = axi_out.bvalid === 1'b1;
      rs = axi_out.bresp;
      n++;
      @(posedge sys_clk);
      if (aw) axi_in.awvalid <= 1'b0;
      if (w) axi_in.wvalid <= 1'b0;
    end
    axi_in.bready <= 1'b0;
    // one idle edge so a following call never re-raises bready in the same step
    @(posedge sys_clk);
    if (!b) err_total++;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] rd, output logic [1:0] rs);
    logic ar, v;
    int n;
    n = 0;
    v = 1'b0;
    axi_in.araddr <= a;
    axi_in.arvalid <= 1'b1;
    axi_in.rready <= 1'b1;
    while (!v && n < 100) begin
      @(negedge sys_clk);
      ar = axi_in.arvalid && axi_out.arready === 1'b1;
      v = axi_out.rvalid === 1'b1;
      rd = axi_out.rdata;
      rs = axi_out.rresp;
      n++;
      @(posedge sys_clk);
      if (ar) axi_in.arvalid <= 1'b0;
    end
    axi_in.rready <= 1'b0;
    @(posedge sys_clk);
    if (!v) err_total++;
  endtask
  task automatic ask(input logic [7:0] code, input logic [7:0] m, input logic fl);
    int n;
    n = 0;
    host.got.delete();
    host.send(code, m, fl);
    while (host.got.size() == 0 && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    f = host.got.size() > 0 ? host.got[0] : 'x;
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    axr(8'h20, d, r);
    chk("unmapped read", {MCR_RESP_SLVERR, 32'h0}, {r, d});
    axw(MCR_ADDR_STAT, 32'h1, r);
    chk("ro write", MCR_RESP_SLVERR, r);
    slow <= 1'b1;
    foreach (md[i]) begin
      ask(MCR_CODE_MODE, md[i], md[i] == MCR_MODE_BOOT);
      chk("mode reply", {MCR_CODE_MODE, md[i], {6{MCR_FILL}}}, f);
      chk("mode accepted", md[i], f.b2);
    end
    ask(MCR_CODE_MODE, MCR_MODE_BOOT, 1'b0);
    chk("boot refused", {MCR_CODE_MODE, MCR_MODE_NORMAL, {6{MCR_FILL}}}, f);
    axr(MCR_ADDR_REQ, d, r);
    chk("refused mode", MCR_MODE_BOOT, d[15:8]);
    host.got.delete();
    host.send(8'h33, 8'h00, 1'b0);
    repeat (20) @(posedge sys_clk);
    chk("no reply", 64'h0, 64'(host.got.size()));
    slow <= 1'b0;
    axw(MCR_ADDR_CTRL, 32'h3, r);
    axw(MCR_ADDR_CTRL, 32'h7, r);
    axr(MCR_ADDR_CTRL, d, r);
    chk("phase kept", 8'h03, d[7:0]);
    foreach (cc[i]) begin
      ask(cc[i], 8'h00, 1'b0);
      chk("cal reply", {cc[i], 8'h03, MCR_CAL_FILL, {5{MCR_FILL}}}, f);
    end
    host.got.delete();
    host.t.delete();
    repeat (3 * PER + 20) @(posedge sys_clk);
    chk("repeat count", 64'h3, 64'(host.got.size()));
    chk("repeat gap", 64'(PER), 64'(host.t[2] - host.t[1]));
    chk("repeat frame", {8'h22, 8'h03, MCR_CAL_FILL, {5{MCR_FILL}}}, host.got[2]);
    axr(MCR_ADDR_STAT, d, r);
    chk("cal mode", 32'h000c0209, d);
    axw(MCR_ADDR_CTRL, 32'h100, r);
    repeat (PER) @(posedge sys_clk);
    host.got.delete();
    repeat (2 * PER + 10) @(posedge sys_clk);
    chk("stopped", 64'h0, 64'(host.got.size()));
    ask(MCR_CODE_MODE, 8'h05, 1'b0);
    chk("after abort", {MCR_CODE_MODE, MCR_MODE_NORMAL, {6{MCR_FILL}}}, f);
    axr(MCR_ADDR_TXHI, d, r);
    chk("frame high", 32'h7100ffff, d);
    axr(MCR_ADDR_TXLO, d, r);
    chk("frame low", 32'hffffffff, d);
    final_report();
  end
endmodule
`default_nettype wire
